// File: core/qscs_regs.v
// Purpose: Channel D configuration, channel status and alignment status behind the management bus.
// Assumes: Global register bits arrive as same-clock inputs; pins pass a two-flop synchroniser.
// Notes: The management clock is oversampled, so it must run well below a quarter of clock.
`timescale 1ns/1ps
`default_nettype none
`include "qscs_defines.vh"

module qscs_regs #(
    parameter [4:0] PHY_ADDR = 5'h00,
    parameter [19:0] POR_CYCLES = `QSCS_POR_MAX_NS / `QSCS_CLK_PERIOD_NS - 1
) (
    // Clock and reset.
    input wire clock,
    input wire reset,
    // Management bus pins.
    input wire mdc,
    input wire mdio_in,
    output reg mdio_out,
    output reg mdio_oe,
    // Device pins.
    input wire dev_enable,
    input wire cfg_sel_hi,
    input wire cfg_sel_lo,
    input wire prbs_test_pin,
    input wire comma_align_pin,
    input wire loopback_pin,
    // Global register bits.
    input wire [1:0] glb_mf_sel,
    input wire glb_los_en,
    input wire glb_cfg_hi,
    input wire glb_cfg_lo,
    input wire glb_emph_hi,
    input wire glb_emph_lo,
    input wire glb_loopback,
    input wire glb_prbs_en,
    input wire glb_comma_en,
    input wire glb_pwr_down,
    // Channel events from the datapath.
    input wire io_std_hstl,
    input wire comma_det_d,
    input wire [3:0] tx_fifo_coll,
    input wire [3:0] dec_err,
    input wire [3:0] prbs_err,
    input wire [3:0] sig_loss,
    input wire align_seen,
    input wire [3:0] rx_fifo_coll,
    // Channel D controls.
    output reg mf_pin_d,
    output reg los_det_en_d,
    output reg cfg_hi_eff,
    output reg cfg_lo_eff,
    output reg emph_hi_eff,
    output reg emph_lo_eff,
    output reg loopback_d,
    output reg comma_align_en_d,
    output reg pwr_down_d,
    // Test pattern enables, one bit per channel, and the global write permission.
    output reg [3:0] prbs_en,
    output reg glb_prbs_wr_ok,
    // Device level enables.
    output reg core_enable,
    output reg [3:0] tx_ser_oe,
    output reg [3:0] rx_par_oe,
    output reg rx_par_force_hi,
    output reg rx_par_clk_low,
    output reg por_active
);

    // Synchroniser slot for each pin.
    localparam SY_MDC = 0;
    localparam SY_MDIO = 1;
    localparam SY_EN = 2;
    localparam SY_CHI = 3;
    localparam SY_CLO = 4;
    localparam SY_PRBS = 5;
    localparam SY_COMMA = 6;
    localparam SY_LB = 7;

    // Frame states.
    localparam S_PRE = 3'd0;
    localparam S_ST = 3'd1;
    localparam S_HDR = 3'd2;
    localparam S_TA = 3'd3;
    localparam S_DAT = 3'd4;

    reg [7:0] sync1_ff;
    reg [7:0] sync2_ff;
    reg mdc_prev_ff;
    reg [2:0] state_ff;
    reg [5:0] cnt_ff;
    reg [11:0] hdr_ff;
    reg is_read_ff;
    reg [15:0] shift_ff;
    reg [`QSCS_CFG_WIDTH-1:0] cfg_ff;
    reg [19:0] por_cnt_ff;
    reg stat_clr;
    reg align_clr;
    wire mdc_rise;
    wire bit_in;
    wire [15:0] status_flags;
    wire [4:0] align_flags;
    wire [3:0] loss_ev;
    wire [1:0] mf_sel;
    wire [15:0] cfg_rd;
    wire [4:0] hdr_reg;
    wire hdr_hit;

    // Picks the multifunction pin source from a two-bit select.
    function mf_select;
        input [1:0] sel;
        input hstl;
        input comma;
        input loss;
        input pass;
        begin
            case (sel)
                `QSCS_MF_IO_STD: mf_select = hstl;
                `QSCS_MF_COMMA: mf_select = comma;
                `QSCS_MF_LOSS: mf_select = loss;
                `QSCS_MF_PASS: mf_select = pass;
                default: mf_select = 1'b0;
            endcase
        end
    endfunction

    // Two flops per pin; only the second stage is read by logic.
    always @(posedge clock) begin
        if (reset) begin
            sync1_ff <= 8'h00;
            sync2_ff <= 8'h00;
            mdc_prev_ff <= 1'b0;
        end else begin
            sync1_ff <= {loopback_pin, comma_align_pin, prbs_test_pin, cfg_sel_lo,
                         cfg_sel_hi, dev_enable, mdio_in, mdc};
            sync2_ff <= sync1_ff;
            mdc_prev_ff <= sync2_ff[SY_MDC];
        end
    end

    assign mdc_rise = sync2_ff[SY_MDC] & ~mdc_prev_ff;
    assign bit_in = sync2_ff[SY_MDIO];
    assign hdr_reg = hdr_ff[4:0];
    assign hdr_hit = (hdr_ff[9:5] == PHY_ADDR);
    assign cfg_rd = {`QSCS_CFG_PAD, cfg_ff};

    // Management frame engine: preamble, start, header, turnaround, data.
    always @(posedge clock) begin
        if (reset) begin
            state_ff <= S_PRE;
            cnt_ff <= 6'h00;
            hdr_ff <= 12'h000;
            is_read_ff <= 1'b0;
            shift_ff <= 16'h0000;
            mdio_out <= 1'b0;
            mdio_oe <= 1'b0;
            cfg_ff <= `QSCS_CHD_CFG_RST;
        end else begin
            if (mdc_rise) begin
                case (state_ff)
                    S_PRE: begin
                        mdio_oe <= 1'b0;
                        if (bit_in) begin
                            if (cnt_ff != `QSCS_PRE_ONES) begin
                                cnt_ff <= cnt_ff + 6'h01;
                            end
                        end else begin
                            if (cnt_ff == `QSCS_PRE_ONES) begin
                                state_ff <= S_ST;
                            end
                            cnt_ff <= 6'h00;
                        end
                    end
                    S_ST: begin
                        cnt_ff <= 6'h00;
                        state_ff <= bit_in ? S_HDR : S_PRE;
                    end
                    S_HDR: begin
                        hdr_ff <= {hdr_ff[10:0], bit_in};
                        cnt_ff <= cnt_ff + 6'h01;
                        if (cnt_ff[3:0] == `QSCS_HDR_BITS - 4'h1) begin
                            cnt_ff <= 6'h00;
                            state_ff <= S_TA;
                            is_read_ff <= (hdr_ff[10:9] == `QSCS_OP_READ);
                            if (hdr_ff[10:9] != `QSCS_OP_READ && hdr_ff[10:9] != `QSCS_OP_WRITE) begin
                                state_ff <= S_PRE;
                            end
                        end
                    end
                    S_TA: begin
                        cnt_ff <= cnt_ff + 6'h01;
                        if (cnt_ff[1:0] == 2'h0) begin
                            // Sample the register here; its clear lands on this same edge.
                            if (is_read_ff && hdr_hit) begin
                                mdio_oe <= 1'b1;
                                mdio_out <= 1'b0;
                                case (hdr_reg)
                                    `QSCS_REG_CHD_CFG: shift_ff <= cfg_rd;
                                    `QSCS_REG_CHAN_STATUS: shift_ff <= status_flags;
                                    `QSCS_REG_ALIGN_STATUS: shift_ff <= {`QSCS_ALIGN_PAD, align_flags};
                                    default: shift_ff <= 16'h0000;
                                endcase
                            end
                        end else begin
                            cnt_ff <= 6'h00;
                            state_ff <= S_DAT;
                            if (is_read_ff && hdr_hit) begin
                                mdio_out <= shift_ff[15];
                                shift_ff <= {shift_ff[14:0], 1'b0};
                            end
                        end
                    end
                    S_DAT: begin
                        cnt_ff <= cnt_ff + 6'h01;
                        if (is_read_ff) begin
                            mdio_out <= shift_ff[15];
                            shift_ff <= {shift_ff[14:0], 1'b0};
                        end else begin
                            shift_ff <= {shift_ff[14:0], bit_in};
                        end
                        if (cnt_ff[4:0] == `QSCS_DATA_BITS - 5'h01) begin
                            cnt_ff <= 6'h00;
                            state_ff <= S_PRE;
                            mdio_oe <= 1'b0;
                            mdio_out <= 1'b0;
                            if (!is_read_ff && hdr_hit && hdr_reg == `QSCS_REG_CHD_CFG) begin
                                // Only bits 10 to 0 exist, so upper write data is dropped.
                                cfg_ff[`QSCS_CFG_MF_HI] <= shift_ff[`QSCS_CFG_MF_LO];
                                cfg_ff[`QSCS_CFG_MF_LO] <= shift_ff[`QSCS_CFG_LOS_EN];
                                cfg_ff[`QSCS_CFG_LOS_EN] <= shift_ff[`QSCS_CFG_SEL_HI];
                                if (!sync2_ff[SY_CHI]) begin
                                    cfg_ff[`QSCS_CFG_SEL_HI] <= shift_ff[`QSCS_CFG_SEL_LO];
                                end
                                if (!sync2_ff[SY_CLO]) begin
                                    cfg_ff[`QSCS_CFG_SEL_LO] <= shift_ff[`QSCS_CFG_EMPH_HI];
                                end
                                cfg_ff[`QSCS_CFG_EMPH_HI] <= shift_ff[`QSCS_CFG_EMPH_LO];
                                cfg_ff[`QSCS_CFG_EMPH_LO] <= shift_ff[`QSCS_CFG_LOOPBACK];
                                cfg_ff[`QSCS_CFG_LOOPBACK] <= shift_ff[`QSCS_CFG_PRBS];
                                if (!sync2_ff[SY_PRBS]) begin
                                    cfg_ff[`QSCS_CFG_PRBS] <= shift_ff[`QSCS_CFG_COMMA];
                                end
                                cfg_ff[`QSCS_CFG_COMMA] <= shift_ff[`QSCS_CFG_PWR_DOWN];
                                cfg_ff[`QSCS_CFG_PWR_DOWN] <= bit_in;
                            end
                        end
                    end
                    default: begin
                        state_ff <= S_PRE;
                        cnt_ff <= 6'h00;
                        mdio_oe <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Clear on the snapshot edge itself, so a same-edge event wins and stays for the next read.
    always @* begin
        stat_clr = 1'b0;
        align_clr = 1'b0;
        if (mdc_rise && state_ff == S_TA && cnt_ff[1:0] == 2'h0 && is_read_ff && hdr_hit) begin
            stat_clr = (hdr_reg == `QSCS_REG_CHAN_STATUS);
            align_clr = (hdr_reg == `QSCS_REG_ALIGN_STATUS);
        end
    end

    // Signal loss on channel D only counts while its detection is enabled.
    assign loss_ev = {sig_loss[3] & los_det_en_d, sig_loss[2:0]};

    // Channel status flags, from bit 15 down to bit 0.
    qscs_cor_flags #(
        .WIDTH(16),
        .RST_VAL(`QSCS_STATUS_RST)
    ) u_status (
        .clock(clock),
        .reset(reset),
        .event_in({tx_fifo_coll, dec_err, prbs_err, loss_ev}),
        .rd_clr(stat_clr),
        .flags(status_flags)
    );

    // Alignment status flags.
    qscs_cor_flags #(
        .WIDTH(5),
        .RST_VAL(`QSCS_ALIGN_RST)
    ) u_align (
        .clock(clock),
        .reset(reset),
        .event_in({align_seen, rx_fifo_coll}),
        .rd_clr(align_clr),
        .flags(align_flags)
    );

    // Power-on reset counter; counting from zero up to the limit spans exactly the longest allowed time.
    always @(posedge clock) begin
        if (reset) begin
            por_cnt_ff <= 20'h0_0000;
            por_active <= 1'b1;
        end else if (por_active) begin
            por_cnt_ff <= por_cnt_ff + 20'h0_0001;
            if (por_cnt_ff == POR_CYCLES) begin
                por_active <= 1'b0;
            end
        end
    end

    assign mf_sel = {cfg_ff[`QSCS_CFG_MF_HI], cfg_ff[`QSCS_CFG_MF_LO]} | glb_mf_sel;

    // Effective controls are registered so the outputs stay glitch free.
    always @(posedge clock) begin
        if (reset) begin
            mf_pin_d <= 1'b0;
            los_det_en_d <= 1'b0;
            cfg_hi_eff <= 1'b0;
            cfg_lo_eff <= 1'b0;
            emph_hi_eff <= 1'b0;
            emph_lo_eff <= 1'b0;
            loopback_d <= 1'b0;
            comma_align_en_d <= 1'b0;
            pwr_down_d <= 1'b0;
            prbs_en <= 4'h0;
            glb_prbs_wr_ok <= 1'b0;
            core_enable <= 1'b0;
            tx_ser_oe <= 4'h0;
            rx_par_oe <= 4'h0;
            rx_par_force_hi <= 1'b1;
            rx_par_clk_low <= 1'b1;
        end else begin
            mf_pin_d <= mf_select(mf_sel, io_std_hstl, comma_det_d,
                                  status_flags[3], status_flags[7]);
            los_det_en_d <= cfg_ff[`QSCS_CFG_LOS_EN] & glb_los_en;
            cfg_hi_eff <= sync2_ff[SY_CHI] | cfg_ff[`QSCS_CFG_SEL_HI] | glb_cfg_hi;
            cfg_lo_eff <= sync2_ff[SY_CLO] | cfg_ff[`QSCS_CFG_SEL_LO] | glb_cfg_lo;
            emph_hi_eff <= cfg_ff[`QSCS_CFG_EMPH_HI] | glb_emph_hi;
            emph_lo_eff <= cfg_ff[`QSCS_CFG_EMPH_LO] | glb_emph_lo;
            loopback_d <= cfg_ff[`QSCS_CFG_LOOPBACK] | glb_loopback | sync2_ff[SY_LB];
            comma_align_en_d <= cfg_ff[`QSCS_CFG_COMMA] & sync2_ff[SY_COMMA] & glb_comma_en;
            pwr_down_d <= cfg_ff[`QSCS_CFG_PWR_DOWN] | glb_pwr_down;
            // Global bit and pin reach all channels; channel D adds its own bit.
            prbs_en <= {4{glb_prbs_en | sync2_ff[SY_PRBS]}} |
                       {cfg_ff[`QSCS_CFG_PRBS], 3'b000};
            glb_prbs_wr_ok <= ~sync2_ff[SY_PRBS];
            core_enable <= sync2_ff[SY_EN] & ~por_active;
            // Loopback floats channel D's serial output; global loopback floats all four.
            tx_ser_oe <= {4{sync2_ff[SY_EN] & ~glb_loopback}} &
                         {~(cfg_ff[`QSCS_CFG_LOOPBACK] | sync2_ff[SY_LB]), 3'b111};
            rx_par_oe <= {4{sync2_ff[SY_EN] & ~por_active}};
            rx_par_force_hi <= por_active;
            rx_par_clk_low <= por_active | ~sync2_ff[SY_EN];
        end
    end

endmodule

`default_nettype wire

// File: inc/qscs_defines.vh
// Purpose: Shared constants for the channel D configuration and status register block.
// Assumes: A 200 MHz system clock and the management frame of the station management bus.
// Notes: Register numbers are management register addresses, not byte addresses.
`ifndef QSCS_DEFINES_VH
`define QSCS_DEFINES_VH

// Register addresses on the management bus.
`define QSCS_REG_CHD_CFG 5'h14
`define QSCS_REG_CHAN_STATUS 5'h16
`define QSCS_REG_ALIGN_STATUS 5'h17

// Reset values.
`define QSCS_CHD_CFG_RST 11'h102
`define QSCS_STATUS_RST 16'h00F0
`define QSCS_ALIGN_RST 5'h00

// Field positions of the channel D configuration register.
`define QSCS_CFG_MF_HI 10
`define QSCS_CFG_MF_LO 9
`define QSCS_CFG_LOS_EN 8
`define QSCS_CFG_SEL_HI 7
`define QSCS_CFG_SEL_LO 6
`define QSCS_CFG_EMPH_HI 5
`define QSCS_CFG_EMPH_LO 4
`define QSCS_CFG_LOOPBACK 3
`define QSCS_CFG_PRBS 2
`define QSCS_CFG_COMMA 1
`define QSCS_CFG_PWR_DOWN 0
`define QSCS_CFG_WIDTH 11
`define QSCS_CFG_PAD 5'h00
`define QSCS_ALIGN_PAD 11'h000

// Multifunction pin select codes.
`define QSCS_MF_IO_STD 2'h0
`define QSCS_MF_COMMA 2'h1
`define QSCS_MF_LOSS 2'h2
`define QSCS_MF_PASS 2'h3

// Management frame fields.
`define QSCS_PRE_ONES 6'h20
`define QSCS_OP_READ 2'h2
`define QSCS_OP_WRITE 2'h1
`define QSCS_HDR_BITS 4'hC
`define QSCS_DATA_BITS 5'h10
`define QSCS_TA_BITS 2'h2

// Power-on reset timing.
`define QSCS_POR_MAX_NS 1000000
`define QSCS_CLK_PERIOD_NS 5

`endif

// File: core/qscs_cor_flags.v
// Purpose: Vector of sticky status flags that return to their reset value when read.
// Assumes: Events and the read strobe come from logic on the same clock.
// Notes: An event in the cycle of the read strobe wins, so it stays for the next read.
`timescale 1ns/1ps
`default_nettype none

module qscs_cor_flags #(
    parameter WIDTH = 16,
    parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
    // Clock and reset.
    input wire clock,
    input wire reset,
    // Events drive a flag away from its reset value.
    input wire [WIDTH-1:0] event_in,
    // One-cycle strobe on the edge at which the flags are read.
    input wire rd_clr,
    // Current flag values.
    output wire [WIDTH-1:0] flags
);

    reg [WIDTH-1:0] flags_ff;
    reg [WIDTH-1:0] nxt_flags;
    integer i;

    // Per bit the event has priority over the read clear.
    always @* begin
        nxt_flags = flags_ff;
        for (i = 0; i < WIDTH; i = i + 1) begin
            if (event_in[i]) begin
                nxt_flags[i] = ~RST_VAL[i];
            end else if (rd_clr) begin
                nxt_flags[i] = RST_VAL[i];
            end
        end
    end

    // Flag storage.
    always @(posedge clock) begin
        if (reset) begin
            flags_ff <= RST_VAL;
        end else begin
            flags_ff <= nxt_flags;
        end
    end

    assign flags = flags_ff;

endmodule

`default_nettype wire

// File: verif/qscs_regs_props.sv
// Purpose: Concurrent checks on the channel D controls and device enables.
// Assumes: Global bits reach outputs in one edge, pins in three.
// Notes: Power-on length is bounded by a counter, not a long repetition.
`timescale 1ns/1ps
`default_nettype none
module qscs_props #(
    parameter [19:0] POR_CYCLES = 20'h0_0014
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic reset,
    // Watched inputs.
    input wire logic dev_enable,
    input wire logic glb_los_en,
    input wire logic glb_emph_hi,
    input wire logic glb_loopback,
    input wire logic glb_prbs_en,
    input wire logic glb_comma_en,
    input wire logic glb_pwr_down,
    // Watched outputs.
    input wire logic los_det_en_d,
    input wire logic emph_hi_eff,
    input wire logic loopback_d,
    input wire logic comma_align_en_d,
    input wire logic pwr_down_d,
    input wire logic [3:0] prbs_en,
    input wire logic [3:0] tx_ser_oe,
    input wire logic [3:0] rx_par_oe,
    input wire logic core_enable,
    input wire logic rx_par_clk_low,
    input wire logic por_active
);
    reg [19:0] por_cnt_ff;
    wire [19:0] nxt_por_cnt = por_active ? por_cnt_ff + 20'h0_0001 : por_cnt_ff;
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    // Counts power-on cycles so that a hold that never ends is caught.
    always @(posedge clock) begin
        if (reset) begin
            por_cnt_ff <= 20'h0_0000;
        end else begin
            por_cnt_ff <= nxt_por_cnt;
        end
    end
    AST_PWR_DN: assert property (glb_pwr_down |=> pwr_down_d) else $error("power-down ignored");
    AST_LOS_EN: assert property (!glb_los_en |=> !los_det_en_d) else $error("loss enable not gated");
    AST_EMPH: assert property (glb_emph_hi |=> emph_hi_eff) else $error("emphasis not merged");
    AST_LOOP: assert property (glb_loopback |=> loopback_d && tx_ser_oe == 4'h0)
        else $error("loopback output not floated");
    AST_COMMA: assert property (!glb_comma_en |=> !comma_align_en_d) else $error("comma not gated");
    AST_PRBS_ALL: assert property (glb_prbs_en |=> prbs_en == 4'hf) else $error("pattern not on all");
    AST_OFF: assert property (!dev_enable [*5] |-> !core_enable && tx_ser_oe == 4'h0 && rx_par_oe == 4'h0)
        else $error("disabled device still drives");
    AST_POR_HOLD: assert property (por_active |-> rx_par_clk_low && rx_par_oe == 4'h0)
        else $error("power-on hold broken");
    AST_POR_LEN: assert property (por_cnt_ff <= POR_CYCLES + 20'h0_0002) else $error("power-on too long");
endmodule
bind qscs_regs qscs_props #(.POR_CYCLES(POR_CYCLES)) u_props (.clock(clock), .reset(reset),
    .dev_enable(dev_enable), .glb_los_en(glb_los_en), .glb_emph_hi(glb_emph_hi), .glb_loopback(glb_loopback),
    .glb_prbs_en(glb_prbs_en), .glb_comma_en(glb_comma_en), .glb_pwr_down(glb_pwr_down),
    .los_det_en_d(los_det_en_d), .emph_hi_eff(emph_hi_eff), .loopback_d(loopback_d),
    .comma_align_en_d(comma_align_en_d), .pwr_down_d(pwr_down_d), .prbs_en(prbs_en), .tx_ser_oe(tx_ser_oe),
    .rx_par_oe(rx_par_oe), .core_enable(core_enable), .rx_par_clk_low(rx_par_clk_low), .por_active(por_active));
`default_nettype wire

// File: verif/qscs_mdio_mgr.sv
// Purpose: Station management controller that runs whole read and write frames.
// Assumes: Each clock phase of the management clock lasts ten system clocks.
// Notes: The data line floats high through its pull-up once released.
`timescale 1ns/1ps
`default_nettype none
module qscs_mdio_mgr (
    // System clock used only for pacing.
    input wire logic clock,
    input wire logic mdio_line,
    // Management pins driven by this controller.
    output logic mdc,
    output logic m_oe,
    output logic m_dat,
    // Read result, valid while rd_done is high.
    output logic rd_done,
    output logic [15:0] rd_data
);
    // Quiet pins before the first frame.
    initial begin
        {mdc, m_oe, m_dat, rd_done, rd_data} = 20'h0_0000;
    end
    // Bits change while the clock is low and are sampled at its rise.
    task automatic xfer(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd);
        logic [63:0] fr;
        fr = {32'hffff_ffff, 2'b01, op, 5'h00, ra, 2'b10, wd};
        for (int i = 63; i >= 0; i--) begin
            m_oe <= (op == 2'b01) || (i > 17);
            m_dat <= fr[i];
            repeat (10) @(negedge clock);
            mdc <= 1'b1;
            if (i < 16) rd_data <= {rd_data[14:0], mdio_line};
            repeat (10) @(negedge clock);
            mdc <= 1'b0;
        end
        m_oe <= 1'b0;
        rd_done <= (op == 2'b10);
        @(negedge clock);
        rd_done <= 1'b0;
    endtask
endmodule
`default_nettype wire

// File: verif/quad_serdes_chan_cfg_status_regs_tb_top.sv
// Purpose: Self-checking bench for the channel D register block.
// Assumes: Inputs change at the falling clock edge; reads are queued and matched.
// Notes: Power-on length is shortened to 21 cycles.
`timescale 1ns/1ps
`default_nettype none
`include "qscs_defines.vh"
module quad_serdes_chan_cfg_status_regs_tb_top;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic mdc, m_oe, m_dat, rd_done, mdio_out, mdio_oe, e, io_std_hstl, comma_det_d, align_seen;
    logic dev_enable, cfg_sel_hi, cfg_sel_lo, prbs_test_pin, comma_align_pin, loopback_pin;
    logic glb_los_en, glb_cfg_hi, glb_cfg_lo, glb_emph_hi, glb_emph_lo, glb_loopback, glb_prbs_en;
    logic glb_comma_en, glb_pwr_down, mf_pin_d, los_det_en_d, cfg_hi_eff, cfg_lo_eff, emph_hi_eff, emph_lo_eff;
    logic loopback_d, comma_align_en_d, pwr_down_d, glb_prbs_wr_ok, core_enable, rx_par_force_hi, rx_par_clk_low;
    logic por_active;
    logic [1:0] glb_mf_sel, f;
    logic [3:0] tx_fifo_coll, dec_err, prbs_err, sig_loss, rx_fifo_coll, prbs_en, tx_ser_oe, rx_par_oe;
    logic [15:0] rd_data, ev;
    logic [15:0] exp_q[$];
    int num_errors = 0;
    int n_checks = 0;
    wire mdio_line = mdio_oe ? mdio_out : (m_oe ? m_dat : 1'b1);
    qscs_regs #(.POR_CYCLES(20'h0_0014)) uut (.clock(clock), .reset(reset), .mdc(mdc), .mdio_in(mdio_line),
        .mdio_out(mdio_out), .mdio_oe(mdio_oe), .dev_enable(dev_enable), .cfg_sel_hi(cfg_sel_hi),
        .cfg_sel_lo(cfg_sel_lo), .prbs_test_pin(prbs_test_pin), .comma_align_pin(comma_align_pin),
        .loopback_pin(loopback_pin), .glb_mf_sel(glb_mf_sel), .glb_los_en(glb_los_en), .glb_cfg_hi(glb_cfg_hi),
        .glb_cfg_lo(glb_cfg_lo), .glb_emph_hi(glb_emph_hi), .glb_emph_lo(glb_emph_lo), .glb_loopback(glb_loopback),
        .glb_prbs_en(glb_prbs_en), .glb_comma_en(glb_comma_en), .glb_pwr_down(glb_pwr_down),
        .io_std_hstl(io_std_hstl), .comma_det_d(comma_det_d), .tx_fifo_coll(tx_fifo_coll), .dec_err(dec_err),
        .prbs_err(prbs_err), .sig_loss(sig_loss), .align_seen(align_seen), .rx_fifo_coll(rx_fifo_coll),
        .mf_pin_d(mf_pin_d), .los_det_en_d(los_det_en_d), .cfg_hi_eff(cfg_hi_eff), .cfg_lo_eff(cfg_lo_eff),
        .emph_hi_eff(emph_hi_eff), .emph_lo_eff(emph_lo_eff), .loopback_d(loopback_d),
        .comma_align_en_d(comma_align_en_d), .pwr_down_d(pwr_down_d), .prbs_en(prbs_en),
        .glb_prbs_wr_ok(glb_prbs_wr_ok), .core_enable(core_enable), .tx_ser_oe(tx_ser_oe), .rx_par_oe(rx_par_oe),
        .rx_par_force_hi(rx_par_force_hi), .rx_par_clk_low(rx_par_clk_low), .por_active(por_active));
    qscs_mdio_mgr mgr (.clock(clock), .mdio_line(mdio_line), .mdc(mdc), .m_oe(m_oe), .m_dat(m_dat),
        .rd_done(rd_done), .rd_data(rd_data));
    // Free-running system clock.
    always #2.5 clock = ~clock;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [4:0] ra, input logic [15:0] exp);
        exp_q.push_back(exp);
        mgr.xfer(2'b10, ra, 16'h0000);
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Each finished read is matched with the oldest expectation.
    always @(posedge rd_done) begin
        chk(rd_data, exp_q.pop_front());
    end
    // A hung frame counts as a mismatch.
    initial begin
        repeat (80000) @(posedge clock);
        num_errors++;
        complete_run();
    end
    // Main sequence.
    initial begin
        {dev_enable, cfg_sel_hi, cfg_sel_lo, prbs_test_pin, comma_align_pin, loopback_pin} = 6'h22;
        {glb_mf_sel, glb_los_en, glb_cfg_hi, glb_cfg_lo, glb_emph_hi, glb_emph_lo, glb_loopback} = 8'h20;
        {glb_prbs_en, glb_comma_en, glb_pwr_down, io_std_hstl, comma_det_d, align_seen} = 6'h10;
        {tx_fifo_coll, dec_err, prbs_err, sig_loss, rx_fifo_coll} = 20'h0_0000;
        void'($urandom(32'hb7cf_2ed9));
        wait_n(3);
        reset = 1'b0;
        wait_n(1);
        chk({13'h0, por_active, rx_par_clk_low, rx_par_force_hi}, 16'h0007);
        rd(`QSCS_REG_CHD_CFG, 16'h0102);
        chk({11'h0, por_active, los_det_en_d, comma_align_en_d, core_enable, rx_par_oe[3]}, 16'h000f);
        rd(`QSCS_REG_CHAN_STATUS, 16'h00f0);
        rd(`QSCS_REG_ALIGN_STATUS, 16'h0000);
        rd(5'h03, 16'h0000);
        $display("test reset values done");
        mgr.xfer(2'b01, `QSCS_REG_CHD_CFG, 16'hffff);
        rd(`QSCS_REG_CHD_CFG, 16'h07ff);
        comma_align_pin = 1'b0;
        wait_n(5);
        chk({7'h0, pwr_down_d, loopback_d, tx_ser_oe[3], emph_hi_eff, emph_lo_eff, cfg_hi_eff, prbs_en[3],
            comma_align_en_d, cfg_lo_eff}, 16'h01bd);
        {cfg_sel_hi, prbs_test_pin, comma_align_pin} = 3'h7;
        wait_n(5);
        mgr.xfer(2'b01, `QSCS_REG_CHD_CFG, 16'h0000);
        rd(`QSCS_REG_CHD_CFG, 16'h0084);
        chk({11'h0, glb_prbs_wr_ok, prbs_en}, 16'h000f);
        {cfg_sel_hi, prbs_test_pin, loopback_pin} = 3'h1;
        mgr.xfer(2'b01, `QSCS_REG_CHD_CFG, 16'h0102);
        chk({10'h0, loopback_d, tx_ser_oe[3], glb_prbs_wr_ok, cfg_hi_eff, prbs_en[3], pwr_down_d}, 16'h0028);
        loopback_pin = 1'b0;
        $display("test configuration done");
        for (int s = 0; s < 4; s++) begin
            f = 2'(s) & 2'($urandom);
            glb_mf_sel = (2'(s) & ~f) | (2'(s) & 2'($urandom));
            {io_std_hstl, comma_det_d} = 2'($urandom);
            mgr.xfer(2'b01, `QSCS_REG_CHD_CFG, {5'h00, f, 9'h102});
            e = (s == 0) ? io_std_hstl : (s == 1) ? comma_det_d : (s == 3);
            chk({15'h0, mf_pin_d}, {15'h0, e});
        end
        glb_mf_sel = 2'h0;
        $display("test pin select done");
        ev = 16'($urandom);
        wait_n(1);
        {tx_fifo_coll, dec_err, prbs_err, sig_loss} = ev;
        {align_seen, rx_fifo_coll} = 5'h1a;
        wait_n(1);
        {tx_fifo_coll, dec_err, prbs_err, sig_loss, rx_fifo_coll, align_seen} = 21'h00_0000;
        rd(`QSCS_REG_CHAN_STATUS, {ev[15:8], ~ev[7:4], ev[3:0]});
        rd(`QSCS_REG_CHAN_STATUS, 16'h00f0);
        rd(`QSCS_REG_ALIGN_STATUS, 16'h001a);
        rd(`QSCS_REG_ALIGN_STATUS, 16'h0000);
        glb_los_en = 1'b0;
        wait_n(2);
        sig_loss = 4'h8;
        wait_n(1);
        sig_loss = 4'h0;
        rd(`QSCS_REG_CHAN_STATUS, 16'h00f0);
        $display("test status flags done");
        {glb_pwr_down, glb_loopback, glb_prbs_en, glb_emph_hi, glb_comma_en, glb_cfg_hi} = 6'h3d;
        wait_n(3);
        chk({7'h0, pwr_down_d, loopback_d, emph_hi_eff, comma_align_en_d, cfg_hi_eff, prbs_en}, 16'h01df);
        {glb_pwr_down, glb_loopback, glb_prbs_en, glb_emph_hi, glb_comma_en, glb_cfg_hi, dev_enable} = 7'h08;
        wait_n(6);
        chk({5'h0, rx_par_force_hi, core_enable, tx_ser_oe, rx_par_oe, rx_par_clk_low}, 16'h0001);
        dev_enable = 1'b1;
        wait_n(6);
        $display("test global bits and enable done");
        complete_run();
    end
endmodule
`default_nettype wire
